// [link_ctrl_consts.vh]
`ifndef LINK_CTRL_CONSTS_VH
`define LINK_CTRL_CONSTS_VH
// ==========================================================
// Timing
`define CLK_PERIOD_NS    5
`define PB_DEBOUNCE_NS   10000000
// ==========================================================
// Register byte addresses
`define A_DEV_TYPE       8'h00
`define A_BUS_SC         8'h04
`define A_MEM_OFFSET     8'h08
`define A_MODULE_SC      8'h0C
`define A_SHARED_SC      8'h10
`define A_BUS_INT_ST     8'h14
`define A_IRQ_ROUTE      8'h18
`define A_TRIG_ROUTE     8'h1C
`define A_UTIL_ROUTE     8'h20
`define A_EVT_STATUS     8'h24
`define A_EVT_MASK       8'h28
`define A_EEPROM_CFG     8'h2C
// ==========================================================
// Field positions
`define BSC_SPACE_EN     0
`define BSC_A32_SEL      1
`define BSC_SYSF_INH     2
`define MSC_INTERLOCK    0
`define MSC_SOFT_RST     1
`define BIS_BACKOFF      0
`define UTL_SYSRESET     0
`define UTL_ACFAIL       1
`define UTL_SYSFAIL      2
`define EVT_BACKOFF      0
`define EVT_ACFAIL       1
`define EVT_SYSFAIL      2
// ==========================================================
// Reset values and codes
`define SHARED_RST       4'h0
`define EE_ARB_NORMAL    8'h00
`define EE_ARB_INTERLOCK 8'h01
`define ZERO32           32'h00000000
`endif

// [link_ctrl_props.sv]
`timescale 1ns/100ps
`default_nettype none
`include "link_ctrl_consts.vh"
module link_ctrl_props #(
   parameter DEBOUNCE_CYCLES = 8
) (
   // Clock, reset and register bus
   input wire logic        i_clock,
   input wire logic        i_rstn,
   input wire logic [7:0]  i_address,
   input wire logic        i_read,
   input wire logic        i_write,
   input wire logic [31:0] i_writedata,
   input wire logic        o_waitrequest,
   // EEPROM image and front panel
   input wire logic [7:0]  i_ee_arb_a,
   input wire logic [7:0]  i_ee_arb_b,
   input wire logic [3:0]  i_ee_shared_cfg,
   input wire logic [7:0]  i_ee_link_timer,
   input wire logic        i_pushbutton_n,
   // Backplane and link lines
   input wire logic [7:0]  i_vme_trig_n,
   input wire logic [7:1]  o_vme_irq,
   input wire logic [7:0]  o_vme_trig,
   input wire logic [2:0]  o_vme_util,
   input wire logic [2:0]  o_vme_util_oe_n,
   input wire logic [7:0]  o_link_trig,
   // Configuration outputs
   input wire logic        o_interlock_mode,
   input wire logic [3:0]  o_shared_cfg,
   input wire logic [7:0]  o_link_timer
);
   // ====
   // Shadow of written control bits and a press length counter
   logic       inh_q;
   logic [7:0] trg_en;
   int         pb_cnt;
   wire        wr_ok = i_write && !o_waitrequest;
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         inh_q  <= 1'b0;
         trg_en <= 8'h00;
         pb_cnt <= 0;
      end else begin
         if (wr_ok && i_address == `A_BUS_SC) inh_q <= i_writedata[`BSC_SYSF_INH];
         if (wr_ok && i_address == `A_TRIG_ROUTE) trg_en <= i_writedata[7:0];
         // Saturates so a long press cannot wrap back into range
         pb_cnt <= i_pushbutton_n ? 0 : (pb_cnt < 4000 ? pb_cnt + 1 : pb_cnt);
      end
   end
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rstn);
   // ====
   // Handshake, configuration load and routing
   wait_one_a: assert property (
      !o_waitrequest |=> o_waitrequest) else $error("waitrequest low too long");
   wait_bound_a: assert property (
      (i_read || i_write) && o_waitrequest |-> ##[1:3] !o_waitrequest)
      else $error("request not answered");
   ans_cause_a: assert property (
      !o_waitrequest |-> $past(i_read || i_write)) else $error("answer without request");
   ee_load_a: assert property (
      $rose(i_rstn) |-> ##2 o_interlock_mode == (i_ee_arb_a == 8'h01 && i_ee_arb_b == 8'h01)
      && o_link_timer == i_ee_link_timer && o_shared_cfg == i_ee_shared_cfg)
      else $error("EEPROM values not loaded after reset");
   sysf_inh_a: assert property (
      inh_q && $past(inh_q, 4) |-> o_vme_util_oe_n[`UTL_SYSFAIL])
      else $error("SYSFAIL driven while inhibited");
   pb_reset_a: assert property (
      pb_cnt >= DEBOUNCE_CYCLES + 8 |-> !o_vme_util_oe_n[`UTL_SYSRESET])
      else $error("press does not drive SYSRESET");
   trig_fwd_a: assert property (
      $fell(i_vme_trig_n[0]) && trg_en[0] |-> ##[1:5] o_link_trig[0])
      else $error("trigger not forwarded to link");
   od_zero_a: assert property (
      o_vme_irq == 7'h00 && o_vme_trig == 8'h00 && o_vme_util == 3'h0)
      else $error("open drain line driven high");
   c_read: cover property (i_read && !o_waitrequest);
   c_press: cover property (!o_vme_util_oe_n[`UTL_SYSRESET]);
   c_trig: cover property (o_link_trig[0]);
endmodule
bind vxi_cable_link_control_routing link_ctrl_props #(
   .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (.*);
`default_nettype wire

// [link_peer_model.sv]
`timescale 1ns/100ps
`default_nettype none
module link_peer_model (
   // Bench clock
   input  wire logic       i_clock,
   // Lines toward the block
   output var  logic       o_link_clk,
   output var  logic [7:1] o_irq,
   output var  logic [7:0] o_trig,
   output var  logic [2:0] o_util
);
   // ====
   // Idle link: clock parked low between frames
   initial begin
      o_link_clk = 1'b0;
      o_irq = 7'h00;
      o_trig = 8'h00;
      o_util = 3'h0;
   end
   // Lines settle first, then two 160 ns link clock periods
   task automatic send(input logic [7:1] irq, input logic [7:0] trig, input logic [2:0] util);
      @(posedge i_clock);
      o_irq  <= irq;
      o_trig <= trig;
      o_util <= util;
      repeat (4) begin
         repeat (16) @(posedge i_clock);
         o_link_clk <= ~o_link_clk;
      end
   endtask
endmodule
`default_nettype wire

// [vxi_cable_link_control_routing.v]
// Summary of operation
// - Pushbutton always drives SYSRESET, never ACFAIL
// - Register config lost on reset; EEPROM persists
// - Link settings via register or EEPROM; bus EEPROM-only
// - Offset register, memory field, address-space enable
// - Sysfail inhibit bit blocks SYSFAIL drive
// - Backoff flag clears when read
// - Seven link irqs; local conditions routed via levels
// - Utility lines cross link; no SYSRESET interrupt
// - No trigger interrupts; triggers forwarded to link
// - One link carries utility, irq, trigger, clock lines
// - Link timer from EEPROM, no long-timeout bit
// - Two EEPROM bytes select normal or interlocked
// - Interlock bit loads EEPROM value on hard reset
`timescale 1ns/100ps
`default_nettype none
`include "link_ctrl_consts.vh"
module vxi_cable_link_control_routing #(
   parameter        DEBOUNCE_CYCLES = `PB_DEBOUNCE_NS / `CLK_PERIOD_NS,
   parameter        DB_W            = 24,
   parameter [11:0] MODEL_CODE      = 12'h5A3, // Arbitrary value
   parameter [3:0]  REQ_MEM_FIELD   = 4'hD
) (
   // Clock, reset, enable
   input  wire        i_clock,
   input  wire        i_rstn,
   input  wire        i_clk_en,
   // Avalon-MM slave
   input  wire [7:0]  i_address,
   input  wire        i_read,
   input  wire        i_write,
   input  wire [31:0] i_writedata,
   input  wire [3:0]  i_byteenable,
   output reg  [31:0] o_readdata,
   output reg         o_waitrequest,
   output reg         o_irq,
   // EEPROM image (persistent contents)
   input  wire [7:0]  i_ee_arb_a,
   input  wire [7:0]  i_ee_arb_b,
   input  wire [3:0]  i_ee_shared_cfg,
   input  wire [3:0]  i_ee_bus_timeout,
   input  wire [1:0]  i_ee_bus_req_level,
   input  wire [7:0]  i_ee_link_timer,
   // Local events and front panel
   input  wire        i_backoff,
   input  wire        i_selftest_fail,
   input  wire        i_pushbutton_n,
   // Backplane lines, active low, open drain
   input  wire [7:1]  i_vme_irq_n,
   input  wire [7:0]  i_vme_trig_n,
   input  wire [2:0]  i_vme_util_n,
   output reg  [7:1]  o_vme_irq,
   output reg  [7:1]  o_vme_irq_oe_n,
   output reg  [7:0]  o_vme_trig,
   output reg  [7:0]  o_vme_trig_oe_n,
   output reg  [2:0]  o_vme_util,
   output reg  [2:0]  o_vme_util_oe_n,
   // Cable link, active high
   input  wire        i_link_clk,
   input  wire [7:1]  i_link_irq,
   input  wire [7:0]  i_link_trig,
   input  wire [2:0]  i_link_util,
   output reg  [7:1]  o_link_irq,
   output reg  [7:0]  o_link_trig,
   output reg  [2:0]  o_link_util,
   // Configuration seen by other logic
   output reg         o_interlock_mode,
   output reg  [3:0]  o_shared_cfg,
   output reg  [7:0]  o_link_timer
);
   // ==========================================================
   // Synchronisers
   reg  [17:0] vme_s1_reg;
   reg  [17:0] vme_s2_reg;
   reg  [18:0] lnk_s1_reg;
   reg  [18:0] lnk_s2_reg;
   reg         lclk_d_reg;
   reg  [17:0] lnk_cap_reg;
   reg  [17:0] lnk_prev_reg;
   reg         pb_s1_reg;
   reg         pb_s2_reg;
   // Debounce
   reg         pb_state_reg;
   reg  [DB_W-1:0] db_cnt_reg;
   // Bus slave and registers
   reg         ee_load_reg;
   reg         space_en_reg;
   reg         a32_sel_reg;
   reg         sysf_inh_reg;
   reg  [15:0] mem_off_reg;
   reg         interlock_reg;
   reg  [3:0]  shared_reg;
   reg         backoff_reg;
   reg  [2:0]  loc_level_reg;
   reg  [7:1]  irq_to_reg;
   reg  [7:1]  irq_from_reg;
   reg  [7:0]  trig_to_reg;
   reg  [7:0]  trig_from_reg;
   reg  [2:0]  util_to_reg;
   reg  [2:0]  util_from_reg;
   reg  [2:0]  evt_st_reg;
   reg  [2:0]  evt_mask_reg;
   reg  [3:0]  bus_to_reg;
   reg  [1:0]  bus_lvl_reg;
   reg  [31:0] rd_next;
   reg  [7:1]  loc_hot;
   integer     k;

   // ==========================================================
   // Request decode; a request is served one cycle after it rises
   wire        req     = i_read | i_write;
   wire        hit     = req & ~o_waitrequest;
   wire        wr_hit  = hit & i_write;
   wire        rd_hit  = hit & i_read;
   wire [31:0] wmask   = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                          {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
   wire [31:0] wd      = i_writedata & wmask;
   wire        soft_rst = wr_hit && i_address == `A_MODULE_SC
                          && wd[`MSC_SOFT_RST];

   // Link-side views, valid after capture on link clock rising edges; backplane views from the synchronisers
   wire        lclk_rise = lnk_s2_reg[18] & ~lclk_d_reg;
   wire [7:1]  l_irq     = lnk_cap_reg[6:0];
   wire [7:0]  l_trig    = lnk_cap_reg[14:7];
   wire [2:0]  l_util    = lnk_cap_reg[17:15];
   wire [2:0]  l_util_rise = l_util & ~lnk_prev_reg[17:15];
   wire [7:1]  v_irq     = ~vme_s2_reg[6:0];
   wire [7:0]  v_trig    = ~vme_s2_reg[14:7];
   wire [2:0]  v_util    = ~vme_s2_reg[17:15];

   // Events: SYSRESET from the link never raises one, nor does a trigger
   wire [2:0]  evt_set   = {l_util_rise[`UTL_SYSFAIL] & util_from_reg[`UTL_SYSFAIL],
                            l_util_rise[`UTL_ACFAIL] & util_from_reg[`UTL_ACFAIL],
                            i_backoff};
   wire [2:0]  evt_clr   = (rd_hit && i_address == `A_EVT_STATUS) ? 3'h7 : 3'h0;
   wire        bo_clr    = rd_hit && i_address == `A_BUS_INT_ST;
   wire        loc_pend  = |(evt_st_reg & evt_mask_reg);

   // Interlock follows the EEPROM only when both bytes say so
   wire        ee_interlock = (i_ee_arb_a == `EE_ARB_INTERLOCK)
                              && (i_ee_arb_b == `EE_ARB_INTERLOCK);

   // Local condition goes onto the selected backplane level
   always @* begin
      loc_hot = 7'h00;
      for (k = 1; k < 8; k = k + 1) begin
         if (loc_pend && loc_level_reg == k[2:0]) begin
            loc_hot[k] = 1'b1;
         end
      end
   end

   // ==========================================================
   // Read mux
   always @* begin
      case (i_address)
         `A_DEV_TYPE:   rd_next = {16'h0000, REQ_MEM_FIELD, MODEL_CODE};
         `A_BUS_SC:     rd_next = {24'h000000, v_util, 2'h0,
                                   sysf_inh_reg, a32_sel_reg, space_en_reg};
         `A_MEM_OFFSET: rd_next = {16'h0000, mem_off_reg};
         `A_MODULE_SC:  rd_next = {31'h00000000, interlock_reg};
         `A_SHARED_SC:  rd_next = {28'h0000000, shared_reg};
         `A_BUS_INT_ST: rd_next = {30'h00000000, loc_pend, backoff_reg};
         `A_IRQ_ROUTE:  rd_next = {9'h000, irq_from_reg, 1'b0, irq_to_reg,
                                   5'h00, loc_level_reg};
         `A_TRIG_ROUTE: rd_next = {16'h0000, trig_from_reg, trig_to_reg};
         `A_UTIL_ROUTE: rd_next = {25'h0000000, util_from_reg, 1'b0, util_to_reg};
         `A_EVT_STATUS: rd_next = {29'h00000000, evt_st_reg};
         `A_EVT_MASK:   rd_next = {29'h00000000, evt_mask_reg};
         `A_EEPROM_CFG: rd_next = {16'h0000, o_link_timer, 2'h0, bus_lvl_reg,
                                   bus_to_reg};
         default:       rd_next = `ZERO32;
      endcase
   end

   // ==========================================================
   // Synchronisers and link clock edge capture
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         vme_s1_reg   <= 18'h3FFFF;
         vme_s2_reg   <= 18'h3FFFF;
         lnk_s1_reg   <= 19'h00000;
         lnk_s2_reg   <= 19'h00000;
         lclk_d_reg   <= 1'b0;
         lnk_cap_reg  <= 18'h00000;
         lnk_prev_reg <= 18'h00000;
         pb_s1_reg    <= 1'b1;
         pb_s2_reg    <= 1'b1;
      end else if (i_clk_en) begin
         vme_s1_reg   <= {i_vme_util_n, i_vme_trig_n, i_vme_irq_n};
         vme_s2_reg   <= vme_s1_reg;
         lnk_s1_reg   <= {i_link_clk, i_link_util, i_link_trig, i_link_irq};
         lnk_s2_reg   <= lnk_s1_reg;
         lclk_d_reg   <= lnk_s2_reg[18];
         lnk_prev_reg <= lnk_cap_reg;
         pb_s1_reg    <= i_pushbutton_n;
         pb_s2_reg    <= pb_s1_reg;
         // Peer lines are taken only on a link clock rising edge
         if (lclk_rise) begin
            lnk_cap_reg <= lnk_s2_reg[17:0];
         end
      end
   end

   // ==========================================================
   // Pushbutton debounce: a level must hold the full count to count
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         pb_state_reg <= 1'b0;
         db_cnt_reg   <= {DB_W{1'b0}};
      end else if (i_clk_en) begin
         if (~pb_s2_reg == pb_state_reg) begin
            db_cnt_reg <= {DB_W{1'b0}};
         end else if (db_cnt_reg == DEBOUNCE_CYCLES[DB_W-1:0] - 1'b1) begin
            db_cnt_reg   <= {DB_W{1'b0}};
            pb_state_reg <= ~pb_s2_reg;
         end else begin
            db_cnt_reg <= db_cnt_reg + 1'b1;
         end
      end
   end

   // ==========================================================
   // Avalon slave handshake and register file
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_waitrequest <= 1'b1;
         o_readdata    <= `ZERO32;
         ee_load_reg   <= 1'b1;
         space_en_reg  <= 1'b0;
         a32_sel_reg   <= 1'b0;
         sysf_inh_reg  <= 1'b0;
         mem_off_reg   <= 16'h0000;
         interlock_reg <= 1'b0;
         shared_reg    <= `SHARED_RST;
         backoff_reg   <= 1'b0;
         loc_level_reg <= 3'h0;
         irq_to_reg    <= 7'h00;
         irq_from_reg  <= 7'h00;
         trig_to_reg   <= 8'h00;
         trig_from_reg <= 8'h00;
         util_to_reg   <= 3'h0;
         util_from_reg <= 3'h0;
         evt_st_reg    <= 3'h0;
         evt_mask_reg  <= 3'h0;
         bus_to_reg    <= 4'h0;
         bus_lvl_reg   <= 2'h0;
         o_link_timer  <= 8'h00;
      end else if (i_clk_en) begin
         // One wait cycle, then a single ready cycle per request
         if (req && o_waitrequest) begin
            o_waitrequest <= 1'b0;
            o_readdata    <= rd_next;
         end else begin
            o_waitrequest <= 1'b1;
         end
         // EEPROM values are taken once after every hard reset
         if (ee_load_reg) begin
            ee_load_reg   <= 1'b0;
            interlock_reg <= ee_interlock;
            shared_reg    <= i_ee_shared_cfg;
            bus_to_reg    <= i_ee_bus_timeout;
            bus_lvl_reg   <= i_ee_bus_req_level;
            o_link_timer  <= i_ee_link_timer;
         end
         if (wr_hit) begin
            case (i_address)
               `A_BUS_SC: begin
                  space_en_reg <= wd[`BSC_SPACE_EN] | (space_en_reg & ~wmask[0]);
                  a32_sel_reg  <= wd[`BSC_A32_SEL] | (a32_sel_reg & ~wmask[0]);
                  sysf_inh_reg <= wd[`BSC_SYSF_INH] | (sysf_inh_reg & ~wmask[0]);
               end
               `A_MEM_OFFSET: mem_off_reg <= wd[15:0] | (mem_off_reg & ~wmask[15:0]);
               `A_MODULE_SC: begin
                  interlock_reg <= wd[`MSC_INTERLOCK] | (interlock_reg & ~wmask[0]);
               end
               `A_SHARED_SC: shared_reg <= wd[3:0] | (shared_reg & ~wmask[3:0]);
               `A_IRQ_ROUTE: begin
                  loc_level_reg <= wd[2:0] | (loc_level_reg & ~wmask[2:0]);
                  irq_to_reg    <= wd[14:8] | (irq_to_reg & ~wmask[14:8]);
                  irq_from_reg  <= wd[22:16] | (irq_from_reg & ~wmask[22:16]);
               end
               `A_TRIG_ROUTE: begin
                  trig_to_reg   <= wd[7:0] | (trig_to_reg & ~wmask[7:0]);
                  trig_from_reg <= wd[15:8] | (trig_from_reg & ~wmask[15:8]);
               end
               `A_UTIL_ROUTE: begin
                  util_to_reg   <= wd[2:0] | (util_to_reg & ~wmask[2:0]);
                  util_from_reg <= wd[6:4] | (util_from_reg & ~wmask[6:4]);
               end
               `A_EVT_MASK: evt_mask_reg <= wd[2:0] | (evt_mask_reg & ~wmask[2:0]);
               default: ;
            endcase
         end
         // Sticky flags: a new event wins over a read clear
         backoff_reg <= (backoff_reg & ~bo_clr & ~soft_rst) | i_backoff;
         evt_st_reg  <= (evt_st_reg & ~evt_clr & {3{~soft_rst}}) | evt_set;
      end
   end

   // ==========================================================
   // Line routing; enabling both directions on one line latches it
   always @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_irq            <= 1'b0;
         o_vme_irq        <= 7'h00;
         o_vme_irq_oe_n   <= 7'h7F;
         o_vme_trig       <= 8'h00;
         o_vme_trig_oe_n  <= 8'hFF;
         o_vme_util       <= 3'h0;
         o_vme_util_oe_n  <= 3'h7;
         o_link_irq       <= 7'h00;
         o_link_trig      <= 8'h00;
         o_link_util      <= 3'h0;
         o_interlock_mode <= 1'b0;
         o_shared_cfg     <= `SHARED_RST;
      end else if (i_clk_en) begin
         o_irq            <= loc_pend;
         o_interlock_mode <= interlock_reg;
         o_shared_cfg     <= shared_reg;
         // Backplane drives (low enable = pulling the line low)
         o_vme_irq_oe_n  <= ~((l_irq & irq_from_reg) | loc_hot);
         o_vme_trig_oe_n <= ~(l_trig & trig_from_reg);
         o_vme_util_oe_n[`UTL_SYSRESET] <= ~(pb_state_reg
            | (l_util[`UTL_SYSRESET] & util_from_reg[`UTL_SYSRESET]));
         o_vme_util_oe_n[`UTL_ACFAIL] <= ~(l_util[`UTL_ACFAIL]
            & util_from_reg[`UTL_ACFAIL]);
         o_vme_util_oe_n[`UTL_SYSFAIL] <= ~(~sysf_inh_reg
            & (i_selftest_fail
               | (l_util[`UTL_SYSFAIL] & util_from_reg[`UTL_SYSFAIL])));
         // Forwarding onto the cable link
         o_link_irq  <= v_irq & irq_to_reg;
         o_link_trig <= v_trig & trig_to_reg;
         o_link_util <= v_util & util_to_reg;
      end
   end
endmodule
`default_nettype wire

// [vxi_cable_link_control_routing_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "link_ctrl_consts.vh"
module vxi_cable_link_control_routing_bench;
   localparam int DB = 8;
   // ====
   // Design inputs at their idle or strap levels
   logic        i_clock = 1'b0;
   logic        i_rstn = 1'b0;
   logic        i_clk_en = 1'b1;
   logic [7:0]  i_address = 8'h00;
   logic        i_read = 1'b0;
   logic        i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0;
   logic [3:0]  i_byteenable = 4'hF;
   logic [7:0]  i_ee_arb_a = 8'h01;
   logic [7:0]  i_ee_arb_b = 8'h01;
   logic [3:0]  i_ee_shared_cfg = 4'h9;
   logic [3:0]  i_ee_bus_timeout = 4'h3;
   logic [1:0]  i_ee_bus_req_level = 2'h2;
   logic [7:0]  i_ee_link_timer = 8'h47;
   logic        i_backoff = 1'b0;
   logic        i_selftest_fail = 1'b0;
   logic        i_pushbutton_n = 1'b1;
   // Other backplane modules, high = released
   logic [7:1]  pull_irq_n = 7'h7F;
   logic [7:0]  pull_trig_n = 8'hFF;
   logic [2:0]  pull_util_n = 3'h7;
   logic [31:0] rd;
   int          n_fail = 0;
   int          total_checks = 0;
   wire  [31:0] o_readdata;
   wire         o_waitrequest, o_irq, o_interlock_mode, i_link_clk;
   wire  [7:1]  o_vme_irq, o_vme_irq_oe_n, o_link_irq, i_link_irq, i_vme_irq_n;
   wire  [7:0]  o_vme_trig, o_vme_trig_oe_n, o_link_trig, i_link_trig, i_vme_trig_n;
   wire  [7:0]  o_link_timer;
   wire  [2:0]  o_vme_util, o_vme_util_oe_n, o_link_util, i_link_util, i_vme_util_n;
   wire  [3:0]  o_shared_cfg;
   // Open-drain lines read low when any party pulls them
   assign i_vme_irq_n = pull_irq_n & o_vme_irq_oe_n;
   assign i_vme_trig_n = pull_trig_n & o_vme_trig_oe_n;
   assign i_vme_util_n = pull_util_n & o_vme_util_oe_n;
   always #2.5 i_clock = ~i_clock;
   vxi_cable_link_control_routing #(.DEBOUNCE_CYCLES(DB)) u_dut (.*);
   link_peer_model u_peer (.i_clock(i_clock), .o_link_clk(i_link_clk), .o_irq(i_link_irq),
      .o_trig(i_link_trig), .o_util(i_link_util));
   // ====
   // Shared helpers
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // Holds the request until waitrequest is sampled low
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clock);
      i_read <= !w;
      i_write <= w;
      i_address <= a;
      i_writedata <= d;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 20);
      rd = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
   endtask
   task rdr(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task wrr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task hrst;
      i_rstn <= 1'b0;
      wt(4);
      i_rstn <= 1'b1;
      wt(3);
   endtask
   task backoff_flag;
      i_backoff <= 1'b1;
      wt(1);
      i_backoff <= 1'b0;
      wt(4);
   endtask
   // ====
   // Scenarios
   task t_regs;
      rdr(`A_DEV_TYPE);
      chk("dev_type", 32'hD5A3, {16'h0, rd[15:0]});
      wrr(`A_MEM_OFFSET, 32'h0000BEEF);
      rdr(`A_MEM_OFFSET);
      chk("mem_offset", 32'hBEEF, {16'h0, rd[15:0]});
      // Only the low byte lane may change
      i_byteenable <= 4'h1;
      wrr(`A_MEM_OFFSET, 32'h00001234);
      i_byteenable <= 4'hF;
      rdr(`A_MEM_OFFSET);
      chk("mem_lane", 32'hBE34, {16'h0, rd[15:0]});
      wrr(`A_BUS_SC, 32'h3);
      rdr(`A_BUS_SC);
      chk("space_en", 32'h3, {30'h0, rd[1:0]});
      rdr(`A_EEPROM_CFG);
      chk("ee_cfg", 32'h4723, {16'h0, rd[15:0]});
      rdr(8'hFC);
      chk("unmapped", 32'h0, rd);
      chk("interlock", 32'h1, {31'h0, o_interlock_mode});
   endtask
   task t_persist;
      wrr(`A_SHARED_SC, 32'hF);
      wrr(`A_MODULE_SC, 32'h0);
      // The mode output trails the register by one stage
      wt(2);
      chk("lock_wr", 32'h0, {31'h0, o_interlock_mode});
      i_ee_shared_cfg <= 4'h5;
      hrst;
      rdr(`A_SHARED_SC);
      chk("shared_ee", 32'h5, {28'h0, rd[3:0]});
      rdr(`A_MEM_OFFSET);
      chk("offset_rst", 32'h0, rd);
      chk("lock_ee", 32'h1, {31'h0, o_interlock_mode});
      i_ee_arb_b <= 8'h00;
      hrst;
      chk("lock_mix", 32'h0, {31'h0, o_interlock_mode});
   endtask
   task t_events;
      wrr(`A_EVT_MASK, 32'h1);
      backoff_flag;
      chk("irq_on", 32'h1, {31'h0, o_irq});
      rdr(`A_BUS_INT_ST);
      chk("backoff_flag_1", 32'h1, {31'h0, rd[0]});
      rdr(`A_BUS_INT_ST);
      chk("backoff_flag_2", 32'h0, {31'h0, rd[0]});
      rdr(`A_EVT_STATUS);
      wt(3);
      chk("irq_clr", 32'h0, {31'h0, o_irq});
      wrr(`A_EVT_MASK, 32'h0);
      // A pulse while the enable is low must leave no trace
      i_clk_en <= 1'b0;
      backoff_flag;
      i_clk_en <= 1'b1;
      rdr(`A_EVT_STATUS);
      chk("evt_frozen", 32'h0, rd);
      backoff_flag;
      chk("irq_mask", 32'h0, {31'h0, o_irq});
      rdr(`A_EVT_STATUS);
      chk("evt_bk", 32'h1, rd);
      // Soft reset clears the backoff flag that is still set
      wrr(`A_MODULE_SC, 32'h2);
      rdr(`A_BUS_INT_ST);
      chk("soft_rst", 32'h0, {31'h0, rd[0]});
   endtask
   task t_sysfail;
      i_selftest_fail <= 1'b1;
      wt(6);
      chk("sysf_drv", 32'h0, {31'h0, o_vme_util_oe_n[2]});
      wrr(`A_BUS_SC, 32'h4);
      wt(6);
      chk("sysf_inh", 32'h1, {31'h0, o_vme_util_oe_n[2]});
      i_selftest_fail <= 1'b0;
      wrr(`A_BUS_SC, 32'h0);
   endtask
   task t_route;
      wrr(`A_TRIG_ROUTE, 32'h00005AA5);
      wrr(`A_IRQ_ROUTE, 32'h00055002);
      wrr(`A_UTIL_ROUTE, 32'h00000043);
      wrr(`A_EVT_MASK, 32'h6);
      pull_trig_n <= 8'h5A;
      pull_irq_n <= 7'h2F;
      pull_util_n <= 3'h4;
      wt(8);
      chk("to_trig", 32'hA5, {24'h0, o_link_trig});
      chk("to_irq", 32'h50, {25'h0, o_link_irq});
      chk("to_util", 32'h3, {29'h0, o_link_util});
      u_peer.send(7'h05, 8'h5A, 3'h5);
      wt(8);
      chk("fr_trig", 32'hA5, {24'h0, o_vme_trig_oe_n});
      chk("fr_irq", 32'h78, {25'h0, o_vme_irq_oe_n});
      chk("fr_util", 32'h3, {29'h0, o_vme_util_oe_n});
      chk("irq_link", 32'h1, {31'h0, o_irq});
      rdr(`A_EVT_STATUS);
      chk("evt_link", 32'h4, rd);
      pull_trig_n <= 8'hFF;
      pull_irq_n <= 7'h7F;
      pull_util_n <= 3'h7;
   endtask
   task t_button;
      i_pushbutton_n <= 1'b0;
      wt(3);
      i_pushbutton_n <= 1'b1;
      wt(DB + 8);
      chk("pb_glitch", 32'h3, {30'h0, o_vme_util_oe_n[1:0]});
      i_pushbutton_n <= 1'b0;
      wt(DB + 8);
      chk("pb_press", 32'h2, {30'h0, o_vme_util_oe_n[1:0]});
      i_pushbutton_n <= 1'b1;
      wt(DB + 8);
      chk("pb_free", 32'h3, {30'h0, o_vme_util_oe_n[1:0]});
   endtask
   // ====
   // Verdict and run control
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // A hang cannot pass: the limit counts as a mismatch
   initial begin
      #100000;
      n_fail++;
      end_sim;
   end
   initial begin
      hrst;
      t_regs;
      t_persist;
      t_events;
      t_sysfail;
      t_route;
      t_button;
      end_sim;
   end
endmodule
`default_nettype wire
